//--- logic/adfc_format_ctrl.v
// data format register with serial port and two channel formatters
`timescale 1ns/1ns
`default_nettype none
`include "adfc_map.vh"
module adfc_format_ctrl (
    input wire clock_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire sck_i,
    input wire sdi_i,
    input wire sample_strobe_i,
    input wire [12:0] ch1_raw_i,
    input wire [12:0] ch2_raw_i,
    output reg sdo_o,
    output reg sdo_oe_o,
    output reg [7:0] format_o,
    output wire [12:0] ch1_word_o,
    output wire [12:0] ch2_word_o
);
    // sck is sampled on the system clock, so it must run well below 5 MHz
    reg sck_prev_reg;
    reg [4:0] count_reg;
    reg [14:0] shift_reg;
    reg [7:0] read_reg;
    reg [5:0] format_reg;
    // direction flag kept apart: shift_reg[14] only holds it at rise 16
    reg read_flag_reg;
    wire sck_rise;
    wire frame_done;
    wire is_read;
    wire [6:0] register_index;
    wire [7:0] register_payload;
    assign sck_rise = !cs_n_i && sck_i && !sck_prev_reg;
    assign frame_done = sck_rise && (count_reg == `ADFC_FRAME_BITS - 5'h1);
    assign is_read = shift_reg[14];
    assign register_index = shift_reg[13:7];
    assign register_payload = {shift_reg[6:0], sdi_i};

    function [7:0] read_value;
        input [6:0] index;
        input [5:0] fmt;
        begin
            if (index == `ADFC_ADDR_FORMAT) begin
                read_value = {2'b00, fmt};
            end else begin
                read_value = 8'h00;
            end
        end
    endfunction

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sck_prev_reg <= 1'b0;
            count_reg <= 5'h00;
            shift_reg <= 15'h0_000;
            read_reg <= 8'h00;
            format_reg <= `ADFC_FIELD_RESET;
            read_flag_reg <= 1'b0;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            format_o <= `ADFC_FORMAT_RESET;
        end else begin
            sck_prev_reg <= sck_i;
            if (cs_n_i) begin
                count_reg <= 5'h00;
                sdo_oe_o <= 1'b0;
            end else if (sck_rise && count_reg < `ADFC_FRAME_BITS) begin
                count_reg <= count_reg + 5'h1;
                shift_reg <= {shift_reg[13:0], sdi_i};
                if (count_reg == 5'h0) begin
                    read_flag_reg <= sdi_i;
                end
                if (count_reg == 5'h7) begin
                    read_reg <= read_value({shift_reg[5:0], sdi_i},
                        format_reg);
                end
                if (count_reg >= 5'h8 && count_reg < 5'hf) begin
                    read_reg <= {read_reg[6:0], 1'b0};
                end
            end
            // open drain readback: drive low for zero bits of data phase
            if (!cs_n_i && read_flag_reg && count_reg >= 5'h8 &&
                count_reg <= 5'hf) begin
                sdo_oe_o <= ~read_reg[7];
            end else begin
                sdo_oe_o <= 1'b0;
            end
            if (frame_done && !is_read) begin
                if (register_index == `ADFC_ADDR_RESET &&
                    register_payload[`ADFC_RESET_BIT]) begin
                    format_reg <= `ADFC_FIELD_RESET;
                end else if (register_index == `ADFC_ADDR_FORMAT) begin
                    format_reg <= register_payload[5:0];
                end
            end
            format_o <= {2'b00, format_reg};
        end
    end

    // host is trusted to use only defined pattern codes; others pass data
    adfc_formatter ch1_fmt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sample_strobe_i(sample_strobe_i),
        .raw_word_i(ch1_raw_i),
        .test_pattern_select_i(format_reg[`ADFC_TP_HI:`ADFC_TP_LO]),
        .alternate_polarity_enable_i(format_reg[`ADFC_ABP_BIT]),
        .output_scrambler_enable_i(format_reg[`ADFC_SCR_BIT]),
        .signed_coding_select_i(format_reg[`ADFC_SGN_BIT]),
        .out_word_o(ch1_word_o)
    );
    adfc_formatter ch2_fmt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sample_strobe_i(sample_strobe_i),
        .raw_word_i(ch2_raw_i),
        .test_pattern_select_i(format_reg[`ADFC_TP_HI:`ADFC_TP_LO]),
        .alternate_polarity_enable_i(format_reg[`ADFC_ABP_BIT]),
        .output_scrambler_enable_i(format_reg[`ADFC_SCR_BIT]),
        .signed_coding_select_i(format_reg[`ADFC_SGN_BIT]),
        .out_word_o(ch2_word_o)
    );
endmodule // adfc_format_ctrl
`default_nettype wire

//--- logic/adfc_map.vh
// register offsets, field positions and reset values of the format block
`ifndef ADFC_MAP_VH
`define ADFC_MAP_VH
`define ADFC_ADDR_RESET 7'h00
`define ADFC_ADDR_FORMAT 7'h04
`define ADFC_RESET_BIT 7
`define ADFC_TP_HI 5
`define ADFC_TP_LO 3
`define ADFC_ABP_BIT 2
`define ADFC_SCR_BIT 1
`define ADFC_SGN_BIT 0
`define ADFC_FORMAT_RESET 8'h00
`define ADFC_FIELD_RESET 6'h00
`define ADFC_TP_OFF 3'h0
`define ADFC_TP_ZERO 3'h1
`define ADFC_TP_ONE 3'h3
`define ADFC_TP_CHECKER 3'h5
`define ADFC_TP_ALTERNATE 3'h7
`define ADFC_CHECKER_WORD 13'h1_555
`define ADFC_FRAME_BITS 5'h10
`endif

//--- logic/adfc_formatter.v
// one channel output word formatter: pattern, coding, polarity, scrambler
`timescale 1ns/1ns
`default_nettype none
`include "adfc_map.vh"
module adfc_formatter (
    input wire clock_i,
    input wire rst_i,
    input wire sample_strobe_i,
    input wire [12:0] raw_word_i,
    input wire [2:0] test_pattern_select_i,
    input wire alternate_polarity_enable_i,
    input wire output_scrambler_enable_i,
    input wire signed_coding_select_i,
    output reg [12:0] out_word_o
);
    reg phase_reg;
    reg [12:0] word_next;
    reg [11:0] data_v;
    always @* begin
        data_v = raw_word_i[11:0];
        // polarity mode forces offset binary regardless of coding bit
        if (signed_coding_select_i && !alternate_polarity_enable_i) begin
            data_v[11] = ~data_v[11];
        end
        // scrambler: lsb xor into the upper bits, lsb itself untouched
        if (output_scrambler_enable_i) begin
            data_v[11:1] = data_v[11:1] ^ {11{data_v[0]}};
        end
        if (alternate_polarity_enable_i) begin
            data_v = data_v ^ 12'h0_aaa;
        end
        word_next = {raw_word_i[12], data_v};
        case (test_pattern_select_i)
            `ADFC_TP_OFF: word_next = {raw_word_i[12], data_v};
            `ADFC_TP_ZERO: word_next = 13'h0_000;
            `ADFC_TP_ONE: word_next = 13'h1_fff;
            `ADFC_TP_CHECKER: word_next = phase_reg ?
                ~`ADFC_CHECKER_WORD : `ADFC_CHECKER_WORD;
            `ADFC_TP_ALTERNATE: word_next = phase_reg ?
                13'h1_fff : 13'h0_000;
            default: word_next = {raw_word_i[12], data_v};
        endcase
    end
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= 1'b0;
            out_word_o <= 13'h0_000;
        end else if (sample_strobe_i) begin
            phase_reg <= ~phase_reg;
            out_word_o <= word_next;
        end
    end
endmodule // adfc_formatter
`default_nettype wire

//--- verification/adfc_monitor.sv
// port checks for the data format block
`timescale 1ns/1ns
`default_nettype none
module adfc_monitor (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sample_strobe_i,
    input wire logic [12:0] ch1_raw_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic [7:0] format_o,
    input wire logic [12:0] ch1_word_o,
    input wire logic [12:0] ch2_word_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic cs_q;
    // strobe only while idle, so the register cannot move under it
    wire logic q = cs_n_i && cs_q && sample_strobe_i;
    always_ff @(posedge clock_i) cs_q <= cs_n_i;
    chk_sdo_low: assert property (!sdo_o)
        else $error("sdo high");
    chk_top_bits: assert property (format_o[7:6] == 2'b00)
        else $error("top bits set");
    chk_oe_idle: assert property (cs_n_i [*2] |-> !sdo_oe_o)
        else $error("oe while idle");
    chk_format_hold: assert property (cs_n_i [*3] |-> $stable(format_o))
        else $error("format moved");
    chk_pass_data: assert property (q && format_o == 8'h00
        |=> ch1_word_o == $past(ch1_raw_i)) else $error("pass");
    chk_zero_pat: assert property (q && format_o[5:3] == 3'b001
        |=> (ch1_word_o | ch2_word_o) == 13'h0_000) else $error("zeros");
    chk_one_pat: assert property (q && format_o[5:3] == 3'b011
        |=> (ch1_word_o & ch2_word_o) == 13'h1_fff) else $error("ones");
    chk_checker_pat: assert property (q && format_o[5:3] == 3'b101
        |=> ch1_word_o == ch2_word_o && (ch1_word_o == 13'h1_555
        || ch1_word_o == 13'h0_aaa)) else $error("checker");
    chk_alt_pat: assert property (q && format_o[5:3] == 3'b111
        |=> ch1_word_o == ch2_word_o && (ch1_word_o == 13'h0_000
        || ch1_word_o == 13'h1_fff)) else $error("alternate");
    chk_abp_forces: assert property (q && format_o == 8'h05
        |=> ch1_word_o == ($past(ch1_raw_i) ^ 13'h0aaa)) else $error("abp");
endmodule // adfc_monitor
`default_nettype wire

//--- verification/adfc_host.sv
// host model driving the serial configuration port
`timescale 1ns/1ns
`default_nettype none
module adfc_host (
    input wire logic clock_i,
    input wire logic sdo_oe_i,
    output logic cs_n_o = 1'b1,
    output logic sck_o = 1'b0,
    output logic sdi_o = 1'b0,
    output logic [7:0] rd_o = 8'h00
);
    // h is the hold per sck level; large h models a slow host
    task automatic xfer(input logic [15:0] w, input int h);
        for (int i = 0; i < 16; i++) begin
            @(posedge clock_i) cs_n_o <= 1'b0;
            sdi_o <= w[15-i];
            sck_o <= 1'b1;
            repeat (h) @(posedge clock_i);
            sck_o <= 1'b0;
            repeat (h) @(posedge clock_i);
            // bit d(14-i) stands on sdo from just after rise i+1
            if (i >= 7 && i < 15) rd_o[14-i] <= !sdo_oe_i;
        end
        cs_n_o <= 1'b1;
        sdi_o <= ~sdi_o;
        @(posedge clock_i);
    endtask
endmodule // adfc_host
`default_nettype wire

//--- verification/tb_adc_output_data_format_control.sv
// self-checking bench for the data format block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_output_data_format_control;
    logic clock_i = 1'b0;
    // starts low so that the first assertion makes a real rising edge
    logic rst_i = 1'b0;
    logic stb = 1'b0;
    logic [12:0] raw = 13'h0000;
    logic [12:0] p;
    wire logic cs_n, sck, sdi, sdo, oe;
    wire logic [7:0] rd, fmt;
    wire logic [12:0] w1, w2;
    int fail_count = 0;
    int checks_done = 0;
    // format, sample, expected word; only defined pattern codes
    logic [33:0] rows [7] = '{{8'h00, 13'h1123, 13'h1123},
        {8'h08, 13'h1abc, 13'h0000}, {8'h18, 13'h0123, 13'h1fff},
        {8'h01, 13'h0123, 13'h0923}, {8'h02, 13'h0001, 13'h0fff},
        {8'h05, 13'h0123, 13'h0b89}, {8'hc1, 13'h0123, 13'h0923}};
    adfc_host i_host (.clock_i(clock_i), .sdo_oe_i(oe), .cs_n_o(cs_n),
        .sck_o(sck), .sdi_o(sdi), .rd_o(rd));
    adfc_format_ctrl i_dut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n),
        .sck_i(sck), .sdi_i(sdi), .sample_strobe_i(stb), .ch1_raw_i(raw),
        .ch2_raw_i(raw), .sdo_o(sdo), .sdo_oe_o(oe), .format_o(fmt),
        .ch1_word_o(w1), .ch2_word_o(w2));
    task automatic chk(input string n, input logic [12:0] s, e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic smp(input logic [12:0] r);
        @(posedge clock_i) stb <= 1'b1;
        raw <= r;
        @(posedge clock_i) stb <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer({1'b0, a, d}, 2);
    endtask
    task automatic pat(input logic [7:0] f, input logic [12:0] a, b);
        wr(7'h04, f);
        smp(13'h0000);
        p = w1;
        smp(13'h0000);
        chk("pattern pair", p ^ w1, 13'h1fff);
        chk("pattern", (p === a) ? w1 : p, b);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial forever #50 clock_i = ~clock_i;
    initial begin
        #1_000_000;
        fail_count++;
        test_done;
    end
    initial begin
        rst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        chk("reset format", {5'h00, fmt}, 13'h0000);
        foreach (rows[k]) begin
            wr(7'h04, rows[k][33:26]);
            i_host.xfer({1'b1, 7'h04, 8'h00}, 3);
            chk("readback", {5'h00, rd},
                {5'h00, rows[k][33:26] & 8'h3f});
            chk("format", {5'h00, fmt},
                {5'h00, rows[k][33:26] & 8'h3f});
            smp(rows[k][25:13]);
            chk("word1", w1, rows[k][12:0]);
            chk("word2", w2, rows[k][12:0]);
        end
        pat(8'h28, 13'h1555, 13'h0aaa);
        pat(8'h38, 13'h0000, 13'h1fff);
        wr(7'h00, 8'h80);
        chk("reset cmd", {5'h00, fmt}, 13'h0000);
        wr(7'h04, 8'h0a);
        wr(7'h05, 8'h3f);
        i_host.xfer({1'b1, 7'h05, 8'h00}, 5);
        chk("unmapped", {5'h00, rd}, 13'h0000);
        chk("self clear", {5'h00, fmt}, 13'h000a);
        rst_i <= 1'b1;
        @(posedge clock_i) rst_i <= 1'b0;
        @(posedge clock_i);
        chk("rereset", {5'h00, fmt}, 13'h0000);
        wr(7'h04, 8'h18);
        chk("after rereset", {5'h00, fmt}, 13'h0018);
        test_done;
    end
endmodule // tb_adc_output_data_format_control
bind adfc_format_ctrl adfc_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .sample_strobe_i(sample_strobe_i),
    .ch1_raw_i(ch1_raw_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .format_o(format_o), .ch1_word_o(ch1_word_o), .ch2_word_o(ch2_word_o));
`default_nettype wire
